// ===== pitl_pkg.sv
// Shared constants and types for the patchable interval timer logic
// How it works
// - Edge pulse flags the differentiator flop's coming 0 to 1 change.
// - Inverted input gives a falling-edge pulse; one clock long when gate is high.
// - Cycle counter steps once per comparator rise, whatever its high time.
// - Simple two-state timer: both periods total the wired total; first equals preset.
// - Extended two-state timer: 100-unit length, first period still the preset.
// - Load state clears both state flops and the counter: state A.
// - Running, preset match sets first flop: state B, stop-on-match on.
// - Match at wired total sets the enabled second flop: state C.
// - After 100 units both flops clear and the cycle repeats.
// - Quinary counter returns to zero one microsecond after its carry.
// - Clear input high clears the counter on the next clock, gated or not.
// - Counter modulus is a parameter; here eight, one hundred or 128.
// - Multiple carry timer: carry at 10 shifts ring from A to B.
// - Carry 50 sets hold; hold arms flop on 60; armed gates 80 to C.
// - Carry at 100 shifts ring back to A; sequence repeats.
// - System timer is a three-bit ring with per-state counts from settings.
// - Indefinite mode, B preset 01: B ends one microsecond after comparator high.
// - Indefinite mode: A and C periods run normally from their settings.
// - Counter steps only with carry input and gate both high.
// - Carry output is maximum count and carry input; gate not involved.
// - Load takes effect on the next clock regardless of the gate.
`default_nettype none
package pitl_pkg;
    localparam int CNT_W = 7;
    localparam int TIMER_TOTAL = 100;
    localparam int QUIN_W = 3;
    localparam int QUIN_MOD = 8;
    localparam logic [QUIN_W-1:0] QUIN_MAX = 3'h4;
    localparam logic [CNT_W-1:0] MCO_SHIFT_B = 7'h0A;
    localparam logic [CNT_W-1:0] MCO_HOLD = 7'h32;
    localparam logic [CNT_W-1:0] MCO_ARM = 7'h3C;
    localparam logic [CNT_W-1:0] MCO_SHIFT_C = 7'h50;
    localparam logic [CNT_W-1:0] INDEF_B_PRESET = 7'h01;
    // Recycle delay of one microsecond at 200 MHz
    localparam int CLK_PERIOD_NS = 5;
    localparam int RECYCLE_NS = 1000;
    localparam int US_CYCLES = RECYCLE_NS / CLK_PERIOD_NS;
    localparam int US_W = $clog2(US_CYCLES + 1);
    localparam logic [US_W-1:0] US_LAST = US_W'(US_CYCLES - 2);
    localparam logic [US_W-1:0] US_DONE = US_W'(US_CYCLES - 1);
    localparam logic [2:0] RING_A = 3'h1;
    localparam logic [2:0] RING_B = 3'h2;
    localparam logic [2:0] RING_C = 3'h4;
    localparam int SYNC_W = 4;

    typedef struct packed {
        logic [CNT_W-1:0] a;
        logic [CNT_W-1:0] b;
        logic [CNT_W-1:0] c;
    } pitl_preset_type;

    typedef enum logic [1:0] {SIT_A, SIT_B, SIT_C} pitl_sit_type;
endpackage
`default_nettype wire

// ===== pitl_counter.sv
// Synchronous patchable counter element with carry, gate, clear and load
`timescale 1ns/100ps
`default_nettype none
module pitl_counter
    import pitl_pkg::*;
#(
    parameter int MODULUS = TIMER_TOTAL,
    parameter int W       = CNT_W
) (
    input  wire logic         core_clk,
    input  wire logic         resetn,
    input  wire logic         carry_input,
    input  wire logic         gate_input,
    input  wire logic         clear_input,
    input  wire logic         load_input,
    input  wire logic [W-1:0] load_value,
    output var  logic [W-1:0] count,
    output var  logic         carry_output
);
    // Any modulus that fits W bits can be built by this wrap point
    localparam logic [W-1:0] MAX = W'(MODULUS - 1);

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (clear_input) begin
            cnt_nxt = '0;
        end else if (load_input) begin
            cnt_nxt = load_value;
        end else if (carry_input && gate_input) begin
            cnt_nxt = (cnt_r == MAX) ? '0 : W'(cnt_r + 1'b1);
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Gate left out on purpose so cascades see the carry for the whole wait
    assign carry_output = (cnt_r == MAX) && carry_input;
    assign count = cnt_r;

    chk_cnt_clear: assert property (@(posedge core_clk) disable iff (!resetn)
        clear_input |=> cnt_r == '0)
        else $error("counter did not clear after clear input");
    chk_cnt_hold: assert property (@(posedge core_clk) disable iff (!resetn)
        !(carry_input && gate_input) && !clear_input && !load_input |=> $stable(cnt_r))
        else $error("counter moved without carry and gate");
endmodule
`default_nettype wire

// ===== pitl_top.sv
// Edge differentiator, cycle counter and interval timers on one clock
`timescale 1ns/100ps
`default_nettype none
module pitl_top
    import pitl_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             resetn,
    input  wire logic [1:0]       cmp_in,
    input  wire logic             tick_p_in,
    input  wire logic             tick_v_in,
    input  wire logic             tick_sel,
    input  wire logic             run,
    input  wire logic             edge_invert,
    input  wire logic             edge_gate,
    input  wire logic [CNT_W-1:0] period_preset,
    input  wire logic [CNT_W-1:0] wired_total,
    input  wire pitl_preset_type  sit_preset,
    input  wire logic             indef_en,
    output var  logic             edge_pulse,
    output var  logic [CNT_W-1:0] cycle_count,
    output var  logic             two_state_b,
    output var  logic             stop_on_match,
    output var  logic             tst_second,
    output var  logic             preset_match_pulse,
    output var  logic [2:0]       mco_ring,
    output var  logic [QUIN_W-1:0] quin_count,
    output var  logic [2:0]       sit_ring
);
    // True when an advancing count is about to land on value v
    function automatic logic reaches(input logic adv, input logic [CNT_W-1:0] c,
                                     input logic [CNT_W-1:0] v);
        reaches = adv && (CNT_W'(c + 1'b1) == v);
    endfunction

    function automatic logic [2:0] rot(input logic [2:0] r);
        rot = {r[1:0], r[2]};
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisers, tick select, differentiators
    // ----------------------------------------------------------------
    logic [SYNC_W-1:0] sync1_r, sync2_r, sync1_nxt;
    logic              tick_prev_r, diff_ff_r, cyc_ff_r, edge_pulse_r;
    logic              tick_prev_nxt, diff_ff_nxt, cyc_ff_nxt, edge_pulse_nxt;
    logic              tick, edge_src, edge_comb, cyc_pulse, cmp0, cmp1, tick_lvl;

    assign sync1_nxt = {tick_v_in, tick_p_in, cmp_in};
    assign cmp0 = sync2_r[0];
    assign cmp1 = sync2_r[1];
    assign tick_lvl = tick_sel ? sync2_r[3] : sync2_r[2];

    always_comb begin
        tick = tick_lvl && !tick_prev_r;
        tick_prev_nxt = tick_lvl;
        edge_src = cmp0 ^ edge_invert;
        edge_comb = edge_src && !diff_ff_r;
        // Flop follows only while gated, so a low gate stretches the pulse
        diff_ff_nxt = edge_gate ? edge_src : diff_ff_r;
        edge_pulse_nxt = edge_comb;
        cyc_ff_nxt = cmp0;
        cyc_pulse = cmp0 && !cyc_ff_r;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
            tick_prev_r <= 1'h0;
            diff_ff_r <= 1'h0;
            cyc_ff_r <= 1'h0;
            edge_pulse_r <= 1'h0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync1_r;
            tick_prev_r <= tick_prev_nxt;
            diff_ff_r <= diff_ff_nxt;
            cyc_ff_r <= cyc_ff_nxt;
            edge_pulse_r <= edge_pulse_nxt;
        end
    end

    pitl_counter #(.MODULUS(TIMER_TOTAL), .W(CNT_W)) u_cycle (
        .core_clk     (core_clk),
        .resetn       (resetn),
        .carry_input  (cyc_pulse),
        .gate_input   (1'h1),
        .clear_input  (1'h0),
        .load_input   (1'h0),
        .load_value   ('0),
        .count        (cycle_count),
        .carry_output ()
    );

    // ----------------------------------------------------------------
    // Variable carry counter: two-state and three-state timers
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] tst_cnt, two_cnt;
    logic             adv, tst_wrap, match_pre, match_tot, two_clr;
    logic             ff1_r, ff2_r, match_r, two_b_r;
    logic             ff1_nxt, ff2_nxt, match_nxt, two_b_nxt;

    assign adv = tick && run;

    always_comb begin
        match_pre = reaches(adv, tst_cnt, period_preset);
        match_tot = reaches(adv, tst_cnt, wired_total);
        match_nxt = match_pre || match_tot;
        ff1_nxt = ff1_r;
        ff2_nxt = ff2_r;
        if (!run || tst_wrap) begin
            ff1_nxt = 1'h0;
            ff2_nxt = 1'h0;
        end else begin
            if (match_pre) begin
                ff1_nxt = 1'h1;
            end
            if (match_tot && ff1_r) begin
                ff2_nxt = 1'h1;
            end
        end
        two_clr = !run || reaches(adv, two_cnt, wired_total);
        two_b_nxt = run && (two_cnt >= period_preset);
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ff1_r <= 1'h0;
            ff2_r <= 1'h0;
            match_r <= 1'h0;
            two_b_r <= 1'h0;
        end else begin
            ff1_r <= ff1_nxt;
            ff2_r <= ff2_nxt;
            match_r <= match_nxt;
            two_b_r <= two_b_nxt;
        end
    end

    pitl_counter #(.MODULUS(TIMER_TOTAL), .W(CNT_W)) u_tst (
        .core_clk     (core_clk),
        .resetn       (resetn),
        .carry_input  (tick),
        .gate_input   (run),
        .clear_input  (!run),
        .load_input   (1'h0),
        .load_value   ('0),
        .count        (tst_cnt),
        .carry_output (tst_wrap)
    );

    pitl_counter #(.MODULUS(TIMER_TOTAL), .W(CNT_W)) u_two (
        .core_clk     (core_clk),
        .resetn       (resetn),
        .carry_input  (tick),
        .gate_input   (run),
        .clear_input  (two_clr),
        .load_input   (1'h0),
        .load_value   ('0),
        .count        (two_cnt),
        .carry_output ()
    );

    // ----------------------------------------------------------------
    // Multiple carry timer and quinary counter
    // ----------------------------------------------------------------
    logic [CNT_W-1:0]  mco_cnt;
    logic [2:0]        ring_r, ring_nxt;
    logic              hold_r, arm_r, hold_nxt, arm_nxt, mco_wrap;
    logic [QUIN_W-1:0] quin_cnt;
    logic [US_W-1:0]   qdly_r, qdly_nxt;
    logic              qclr_r, qclr_nxt, quin_full;

    always_comb begin
        ring_nxt = ring_r;
        hold_nxt = hold_r;
        arm_nxt = arm_r;
        if (!run) begin
            ring_nxt = RING_A;
            hold_nxt = 1'h0;
            arm_nxt = 1'h0;
        end else if (mco_wrap) begin
            ring_nxt = rot(ring_r);
            hold_nxt = 1'h0;
            arm_nxt = 1'h0;
        end else begin
            if (reaches(adv, mco_cnt, MCO_SHIFT_B)) begin
                ring_nxt = rot(ring_r);
            end
            if (reaches(adv, mco_cnt, MCO_HOLD)) begin
                hold_nxt = 1'h1;
            end
            if (reaches(adv, mco_cnt, MCO_ARM) && hold_r) begin
                arm_nxt = 1'h1;
            end
            if (reaches(adv, mco_cnt, MCO_SHIFT_C) && arm_r) begin
                ring_nxt = rot(ring_r);
            end
        end
        quin_full = (quin_cnt == QUIN_MAX);
        // Delay restarts from zero each time the carry appears
        qdly_nxt = (quin_full && !qclr_r) ? US_W'(qdly_r + 1'b1) : '0;
        qclr_nxt = quin_full && (qdly_r == US_LAST);
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ring_r <= RING_A;
            hold_r <= 1'h0;
            arm_r <= 1'h0;
            qdly_r <= '0;
            qclr_r <= 1'h0;
        end else begin
            ring_r <= ring_nxt;
            hold_r <= hold_nxt;
            arm_r <= arm_nxt;
            qdly_r <= qdly_nxt;
            qclr_r <= qclr_nxt;
        end
    end

    pitl_counter #(.MODULUS(TIMER_TOTAL), .W(CNT_W)) u_mco (
        .core_clk     (core_clk),
        .resetn       (resetn),
        .carry_input  (tick),
        .gate_input   (run),
        .clear_input  (!run),
        .load_input   (1'h0),
        .load_value   ('0),
        .count        (mco_cnt),
        .carry_output (mco_wrap)
    );

    // Ticks go to carry input, run to gate: the carry must ignore run
    pitl_counter #(.MODULUS(QUIN_MOD), .W(QUIN_W)) u_quin (
        .core_clk     (core_clk),
        .resetn       (resetn),
        .carry_input  (tick && !quin_full),
        .gate_input   (run),
        .clear_input  (qclr_r),
        .load_input   (1'h0),
        .load_value   ('0),
        .count        (quin_cnt),
        .carry_output ()
    );

    // ----------------------------------------------------------------
    // System interval timer with indefinite-operate B period
    // ----------------------------------------------------------------
    pitl_sit_type     sit_r, sit_nxt;
    logic [CNT_W-1:0] sit_cnt, sit_lim;
    logic [US_W-1:0]  idly_r, idly_nxt;
    logic             iarm_r, iarm_nxt, indef_b, sit_done;
    logic [2:0]       sit_ring_r, sit_ring_nxt;

    always_comb begin
        sit_nxt = sit_r;
        sit_lim = sit_preset.a;
        unique case (sit_r)
            SIT_A: sit_lim = sit_preset.a;
            SIT_B: sit_lim = sit_preset.b;
            SIT_C: sit_lim = sit_preset.c;
            default: sit_lim = sit_preset.a;
        endcase
        indef_b = indef_en && (sit_r == SIT_B) && (sit_preset.b == INDEF_B_PRESET);
        iarm_nxt = indef_b && (iarm_r || cmp1);
        idly_nxt = iarm_r ? US_W'(idly_r + 1'b1) : '0;
        sit_done = indef_b ? (iarm_r && idly_r == US_DONE)
                           : reaches(adv, sit_cnt, sit_lim);
        if (!run) begin
            sit_nxt = SIT_A;
        end else if (sit_done) begin
            unique case (sit_r)
                SIT_A: sit_nxt = SIT_B;
                SIT_B: sit_nxt = SIT_C;
                SIT_C: sit_nxt = SIT_A;
                default: sit_nxt = SIT_A;
            endcase
        end
        unique case (sit_nxt)
            SIT_B: sit_ring_nxt = RING_B;
            SIT_C: sit_ring_nxt = RING_C;
            default: sit_ring_nxt = RING_A;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sit_r <= SIT_A;
            iarm_r <= 1'h0;
            idly_r <= '0;
            sit_ring_r <= RING_A;
        end else begin
            sit_r <= sit_nxt;
            iarm_r <= iarm_nxt;
            idly_r <= idly_nxt;
            sit_ring_r <= sit_ring_nxt;
        end
    end

    pitl_counter #(.MODULUS(2 ** CNT_W), .W(CNT_W)) u_sit (
        .core_clk     (core_clk),
        .resetn       (resetn),
        .carry_input  (adv),
        .gate_input   (1'h1),
        .clear_input  (!run || sit_done),
        .load_input   (1'h0),
        .load_value   ('0),
        .count        (sit_cnt),
        .carry_output ()
    );

    assign edge_pulse = edge_pulse_r;
    assign two_state_b = two_b_r;
    assign stop_on_match = ff1_r;
    assign tst_second = ff2_r;
    assign preset_match_pulse = match_r;
    assign mco_ring = ring_r;
    assign quin_count = quin_cnt;
    assign sit_ring = sit_ring_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    localparam int QUIN_LAT = 202;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    chk_edge_predict: assert property (edge_gate && edge_comb |=> diff_ff_r)
        else $error("edge pulse did not precede flop rise");
    chk_edge_len: assert property (edge_gate && edge_comb |=> edge_pulse_r ##1 !edge_pulse_r)
        else $error("gated edge pulse not one clock long");
    chk_cycle_step: assert property (cyc_pulse |=> !cyc_pulse)
        else $error("cycle counter stepped twice for one rise");
    chk_tst_load: assert property (!run |=> tst_cnt == '0 && !ff1_r && !ff2_r)
        else $error("load state not cleared");
    chk_tst_first: assert property (run && match_pre && !tst_wrap |=> ff1_r && stop_on_match)
        else $error("preset match did not enter state B");
    chk_tst_second: assert property (run && match_tot && ff1_r && !tst_wrap |=> ff2_r)
        else $error("total match did not enter state C");
    chk_tst_wrap: assert property (run && tst_wrap |=> !ff1_r && !ff2_r && tst_cnt == '0)
        else $error("timer did not repeat after full cycle");
    chk_match_pulse: assert property (match_pre |=> preset_match_pulse)
        else $error("preset match pulse missing");
    chk_quin_recycle: assert property ($rose(quin_full) |-> ##[1:QUIN_LAT] quin_cnt == '0)
        else $error("quinary counter did not recycle in time");
    chk_mco_shift_b: assert property (run && !mco_wrap && ring_r == RING_A
                                      && reaches(adv, mco_cnt, MCO_SHIFT_B) |=> ring_r == RING_B)
        else $error("carry at ten did not shift ring");
    chk_mco_gate_c: assert property (run && !arm_r
        |=> ring_r != RING_C || $past(ring_r) == RING_C)
        else $error("ring reached C without armed flop");
    chk_mco_wrap: assert property (run && mco_wrap && ring_r == RING_C |=> ring_r == RING_A)
        else $error("carry at hundred did not return ring to A");
    chk_indef_end: assert property ($rose(iarm_r) |-> ##[1:QUIN_LAT] sit_r != SIT_B || !run)
        else $error("indefinite B period outlasted its delay");

    cov_tst_c: cover property (ff1_r && ff2_r);
    cov_mco_c: cover property (ring_r == RING_C);
    cov_quin: cover property (qclr_r);
    cov_indef: cover property (iarm_r ##1 sit_r == SIT_C);
endmodule
`default_nettype wire

// ===== pitl_far_model.sv
// Far-side model: periodic time-unit sources feeding the timer block
`timescale 1ns/100ps
`default_nettype none
module pitl_far_model
    import pitl_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic [7:0] tick_req,
    input  wire logic       tick_go,
    input  wire logic       v_src,
    output var  logic       tick_p_in,
    output var  logic       tick_v_in,
    output var  logic       busy
);
    logic [7:0] left_r;
    logic [1:0] ph_r;
    logic       hi;

    initial begin
        left_r = 8'h00;
        ph_r = 2'h0;
        tick_p_in = 1'b0;
        tick_v_in = 1'b0;
    end

    always_comb begin
        busy = (left_r != 8'h00) || tick_go;
        hi = (left_r != 8'h00) && !tick_go && !ph_r[1];
    end

    // Two cycles high, two low: ticks stay four cycles apart for edge detect
    always @(posedge core_clk) begin
        if (tick_go) begin
            left_r <= tick_req;
            ph_r <= 2'h0;
        end else if (left_r != 8'h00) begin
            ph_r <= ph_r + 2'h1;
            if (ph_r == 2'h3) begin
                left_r <= left_r - 8'h01;
            end
        end
        tick_p_in <= hi && !v_src;
        tick_v_in <= hi && v_src;
    end
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking testbench for the interval timer block
`timescale 1ns/100ps
`default_nettype none
module tb;
    import pitl_pkg::*;
    logic core_clk, resetn, tick_sel, run, edge_invert, edge_gate, indef_en, tick_go;
    logic [1:0] cmp_in;
    logic [CNT_W-1:0] period_preset, wired_total, cycle_count;
    logic [7:0] tick_req;
    pitl_preset_type sit_preset;
    logic tick_p_in, tick_v_in, busy, edge_pulse, two_state_b, stop_on_match, tst_second;
    logic preset_match_pulse, mco_watch;
    logic [2:0] mco_ring, sit_ring, mco_prev, mco_exp;
    logic [QUIN_W-1:0] quin_count;
    logic [2:0] mco_q[$];
    int n_errors, tests_run, n_edge, n_pm, p, t, seed;

    pitl_top dut (.core_clk(core_clk), .resetn(resetn), .cmp_in(cmp_in),
        .tick_p_in(tick_p_in), .tick_v_in(tick_v_in), .tick_sel(tick_sel), .run(run),
        .edge_invert(edge_invert), .edge_gate(edge_gate), .period_preset(period_preset),
        .wired_total(wired_total), .sit_preset(sit_preset), .indef_en(indef_en),
        .edge_pulse(edge_pulse), .cycle_count(cycle_count), .two_state_b(two_state_b),
        .stop_on_match(stop_on_match), .tst_second(tst_second),
        .preset_match_pulse(preset_match_pulse), .mco_ring(mco_ring),
        .quin_count(quin_count), .sit_ring(sit_ring));
    pitl_far_model far (.core_clk(core_clk), .tick_req(tick_req), .tick_go(tick_go),
        .v_src(tick_sel), .tick_p_in(tick_p_in), .tick_v_in(tick_v_in), .busy(busy));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic finish_test();
        $display("Counts: %0d checks, %0d mismatches", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [6:0] act, input logic [6:0] exp, input string msg);
        tests_run++;
        if (act !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, msg, act, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Ask the far side for n ticks, then allow sync and answer latency
    task automatic ticks(input int n);
        int k;
        @(posedge core_clk);
        tick_req <= 8'(n);
        tick_go <= 1'b1;
        @(posedge core_clk);
        tick_go <= 1'b0;
        for (k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge core_clk);
        if (k == 2000) begin
            n_errors++;
            $display("[FAIL] %0t tick source hung", $time);
            finish_test();
        end
        cyc(6);
    endtask

    task automatic pulse_cmp(input int len);
        @(posedge core_clk);
        cmp_in[0] <= 1'b1;
        cyc(len);
        cmp_in[0] <= 1'b0;
        cyc(6);
    endtask

    task automatic set_run(input logic v);
        @(posedge core_clk);
        run <= v;
        cyc(5);
    endtask

    // Result watcher: ring changes are matched against the oldest queued note
    always @(posedge core_clk) begin
        if (edge_pulse === 1'b1) n_edge++;
        if (preset_match_pulse === 1'b1) n_pm++;
        if (mco_watch && mco_ring !== mco_prev) begin
            mco_exp = (mco_q.size() > 0) ? mco_q.pop_front() : 3'h0;
            chk(7'(mco_ring), 7'(mco_exp), "ring step");
        end
        mco_prev <= mco_ring;
    end

    initial begin
        {resetn, run, edge_invert, tick_go, indef_en, tick_sel, mco_watch} = 7'h00;
        {cmp_in, tick_req, period_preset, wired_total} = '0;
        edge_gate = 1'b1;
        sit_preset = '0;
        seed = $urandom(32'hDC6C);
        cyc(10);
        resetn <= 1'b1;
        cyc(2);
        chk(7'(mco_ring), 7'(RING_A), "reset ring");
        chk(7'(sit_ring), 7'(RING_A), "reset sys ring");
        n_edge = 0;
        for (int i = 0; i < 5; i++) pulse_cmp(3 + int'($urandom % 15));
        chk(cycle_count, 7'h05, "cycle count");
        chk(7'(n_edge), 7'h05, "rise pulses");
        edge_gate <= 1'b0;
        @(posedge core_clk);
        cmp_in[0] <= 1'b1;
        cyc(8);
        chk(7'(edge_pulse), 7'h01, "gate low stretch");
        edge_gate <= 1'b1;
        cyc(3);
        chk(7'(edge_pulse), 7'h00, "gate high ends");
        cmp_in[0] <= 1'b0;
        cyc(6);
        chk(cycle_count, 7'h06, "one step per long rise");
        edge_invert <= 1'b1;
        cyc(8);
        n_edge = 0;
        for (int i = 0; i < 3; i++) pulse_cmp(3 + int'($urandom % 15));
        chk(7'(n_edge), 7'h03, "fall pulses");
        edge_invert <= 1'b0;
        $display("Test edge done");
        p = 10 + int'($urandom % 30);
        t = p + 10 + int'($urandom % 30);
        period_preset <= 7'(p);
        wired_total <= 7'(t);
        mco_q = '{RING_B, RING_C, RING_A};
        mco_watch <= 1'b1;
        set_run(1'b1);
        n_pm = 0;
        ticks(p - 1);
        chk(7'(stop_on_match), 7'h00, "before preset");
        chk(7'(two_state_b), 7'h00, "two-state A");
        ticks(1);
        chk(7'(stop_on_match), 7'h01, "preset hit");
        chk(7'(two_state_b), 7'h01, "two-state B");
        ticks(t - p - 1);
        chk(7'(tst_second), 7'h00, "before total");
        ticks(1);
        chk(7'(tst_second), 7'h01, "total hit");
        chk(7'(two_state_b), 7'h00, "two-state wrap");
        ticks(100 - t);
        chk(7'(stop_on_match), 7'h00, "cycle end");
        chk(7'(tst_second), 7'h00, "cycle end 2");
        chk(7'(n_pm), 7'h02, "match pulses");
        chk(7'(mco_q.size()), 7'h00, "ring steps seen");
        mco_watch <= 1'b0;
        ticks(p);
        set_run(1'b0);
        chk(7'(stop_on_match), 7'h00, "load clears");
        chk(7'(mco_ring), 7'(RING_A), "load ring");
        $display("Test timers done");
        tick_sel <= 1'b1;
        sit_preset <= '{a: 7'h03, b: 7'h02, c: 7'h04};
        set_run(1'b1);
        ticks(3);
        chk(7'(sit_ring), 7'(RING_B), "sys A to B");
        ticks(2);
        chk(7'(sit_ring), 7'(RING_C), "sys B to C");
        ticks(4);
        chk(7'(sit_ring), 7'(RING_A), "sys C to A");
        set_run(1'b0);
        sit_preset <= '{a: 7'h03, b: INDEF_B_PRESET, c: 7'h04};
        indef_en <= 1'b1;
        set_run(1'b1);
        ticks(3);
        ticks(5);
        chk(7'(sit_ring), 7'(RING_B), "indef holds");
        cmp_in[1] <= 1'b1;
        cyc(190);
        chk(7'(sit_ring), 7'(RING_B), "indef delay");
        cyc(20);
        chk(7'(sit_ring), 7'(RING_C), "indef end");
        cmp_in[1] <= 1'b0;
        ticks(4);
        chk(7'(sit_ring), 7'(RING_A), "indef C normal");
        $display("Test system timer done");
        set_run(1'b0);
        cyc(250);
        chk(7'(quin_count), 7'h00, "quin idle");
        set_run(1'b1);
        ticks(4);
        chk(7'(quin_count), 7'(QUIN_MAX), "quin max");
        cyc(185);
        chk(7'(quin_count), 7'(QUIN_MAX), "quin holds");
        cyc(15);
        chk(7'(quin_count), 7'h00, "quin recycle");
        $display("Test quinary done");
        finish_test();
    end
endmodule
`default_nettype wire
